/* rtl/xcvr_top.v */
// Registered bidirectional bus transceiver with a Wishbone register window
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "xcvr_defines.vh"
module xcvr_top #(
    parameter HALF_W = `XCVR_HALF_W,
    parameter LOG_DEPTH = `XCVR_LOG_DEPTH
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`XCVR_ADR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire [2*HALF_W-1:0] a_i,
    output wire [2*HALF_W-1:0] a_o,
    output wire [2*HALF_W-1:0] a_oe_o,
    input wire [2*HALF_W-1:0] b_i,
    output wire [2*HALF_W-1:0] b_o,
    output wire [2*HALF_W-1:0] b_oe_o,
    input wire [1:0] a_to_b_capture_clock_i,
    input wire [1:0] b_to_a_capture_clock_i,
    input wire [1:0] drive_en_n_i,
    input wire [1:0] dir_i,
    input wire [1:0] b_side_source_select_i,
    input wire [1:0] a_side_source_select_i,
    output wire log_ready_o
);
    localparam DW = 2*HALF_W;
    localparam LW = 4 + 2*DW;

    reg [`XCVR_CTRL_W-1:0] ctrl_q;
    reg ovf_q;
    reg [7:0] ctl_s1_q, ctl_s2_q;
    wire [1:0] eff_oen, eff_dir, eff_bsel, eff_asel;
    wire [DW-1:0] a_reg, b_reg;
    wire [1:0] cap_a, cap_b, drv_a, drv_b;
    wire [3:0] cap_mask;
    reg [3:0] cap_mask_q;
    wire log_in_valid, log_out_valid, log_pop;
    wire [LW-1:0] log_head;
    wire wb_req, wb_wr, wb_rd;

    // ==================================================
    // Control pin synchronisers
    always @(posedge clk_i) begin
        ctl_s1_q <= {a_side_source_select_i, b_side_source_select_i, dir_i, drive_en_n_i};
        ctl_s2_q <= ctl_s1_q;
    end

    // Software mode takes the controls from the control register
    assign eff_oen = ctrl_q[`XCVR_CTRL_SW_BIT] ? ctrl_q[`XCVR_CTRL_OEN_LSB +: 2] : ctl_s2_q[1:0];
    assign eff_dir = ctrl_q[`XCVR_CTRL_SW_BIT] ? ctrl_q[`XCVR_CTRL_DIR_LSB +: 2] : ctl_s2_q[3:2];
    assign eff_bsel = ctrl_q[`XCVR_CTRL_SW_BIT] ? ctrl_q[`XCVR_CTRL_BSEL_LSB +: 2] : ctl_s2_q[5:4];
    assign eff_asel = ctrl_q[`XCVR_CTRL_SW_BIT] ? ctrl_q[`XCVR_CTRL_ASEL_LSB +: 2] : ctl_s2_q[7:6];

    // ==================================================
    // Two independent halves
    genvar h;
    generate
        for (h = 0; h < `XCVR_HALVES; h = h + 1) begin : g_half
            xcvr_half #(
                .W(HALF_W)
            ) u_half (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .a_pin_i(a_i[h*HALF_W +: HALF_W]),
                .b_pin_i(b_i[h*HALF_W +: HALF_W]),
                .a_to_b_capture_clock_i(a_to_b_capture_clock_i[h]),
                .b_to_a_capture_clock_i(b_to_a_capture_clock_i[h]),
                .drive_en_n_i(eff_oen[h]),
                .dir_i(eff_dir[h]),
                .b_side_source_select_i(eff_bsel[h]),
                .a_side_source_select_i(eff_asel[h]),
                .a_o(a_o[h*HALF_W +: HALF_W]),
                .a_oe_o(drv_a[h]),
                .b_o(b_o[h*HALF_W +: HALF_W]),
                .b_oe_o(drv_b[h]),
                .a_reg_o(a_reg[h*HALF_W +: HALF_W]),
                .b_reg_o(b_reg[h*HALF_W +: HALF_W]),
                .cap_a_o(cap_a[h]),
                .cap_b_o(cap_b[h])
            );
            assign a_oe_o[h*HALF_W +: HALF_W] = {HALF_W{drv_a[h]}};
            assign b_oe_o[h*HALF_W +: HALF_W] = {HALF_W{drv_b[h]}};
        end
    endgenerate

    // ==================================================
    // Capture log
    assign cap_mask = {cap_b, cap_a};

    // Entries are logged one cycle late so they hold the captured data
    always @(posedge clk_i) begin
        if (rst_i) begin
            cap_mask_q <= 4'h0;
        end else begin
            cap_mask_q <= cap_mask;
        end
    end

    assign log_in_valid = |cap_mask_q;

    xcvr_log_fifo #(
        .WIDTH(LW),
        .DEPTH(LOG_DEPTH),
        .AW(2)
    ) u_log (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(log_in_valid),
        .in_ready_o(log_ready_o),
        .in_data_i({cap_mask_q, b_reg, a_reg}),
        .out_valid_o(log_out_valid),
        .out_ready_i(log_pop),
        .out_data_o(log_head)
    );

    // ==================================================
    // Wishbone slave
    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign wb_wr = wb_req & we_i;
    assign wb_rd = wb_req & ~we_i;
    assign log_pop = wb_rd & (adr_i == `XCVR_LOG_DATA_ADR);

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ctrl_q <= `XCVR_CTRL_RST;
            ovf_q <= 1'b0;
        end else begin
            ack_o <= wb_req;
            // Overflow set wins over its clear
            if (log_in_valid & ~log_ready_o) begin
                ovf_q <= 1'b1;
            end else if (wb_wr & (adr_i == `XCVR_STATUS_ADR) & sel_i[0] & dat_i[`XCVR_ST_OVF_BIT]) begin
                ovf_q <= 1'b0;
            end
            if (wb_wr & (adr_i == `XCVR_CTRL_ADR)) begin
                if (sel_i[0]) begin
                    ctrl_q[7:0] <= dat_i[7:0];
                end
                if (sel_i[1]) begin
                    ctrl_q[8] <= dat_i[8];
                end
            end
            if (wb_rd) begin
                case (adr_i)
                    `XCVR_CTRL_ADR: dat_o <= {{(32-`XCVR_CTRL_W){1'b0}}, ctrl_q};
                    `XCVR_STATUS_ADR: dat_o <= {24'h00_0000, drv_b, drv_a, 1'b0, ~log_ready_o,
                        ~log_out_valid, ovf_q};
                    `XCVR_REGS_ADR: dat_o <= {b_reg, a_reg};
                    `XCVR_LOG_MASK_ADR: dat_o <= {23'h00_0000, ~log_out_valid, 4'h0,
                        log_out_valid ? log_head[LW-1 -: 4] : 4'h0};
                    `XCVR_LOG_DATA_ADR: dat_o <= log_out_valid ? log_head[2*DW-1:0] : 32'h0000_0000;
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // xcvr_top

/* rtl/xcvr_defines.vh */
// Constants for the registered bus transceiver and its register window
`ifndef XCVR_DEFINES_VH
`define XCVR_DEFINES_VH

// ==================================================
// Register byte offsets
`define XCVR_CTRL_ADR 8'h00
`define XCVR_STATUS_ADR 8'h04
`define XCVR_REGS_ADR 8'h08
`define XCVR_LOG_MASK_ADR 8'h0c
`define XCVR_LOG_DATA_ADR 8'h10
`define XCVR_ADR_W 8

// ==================================================
// Control register fields
`define XCVR_CTRL_SW_BIT 0
`define XCVR_CTRL_OEN_LSB 1
`define XCVR_CTRL_DIR_LSB 3
`define XCVR_CTRL_BSEL_LSB 5
`define XCVR_CTRL_ASEL_LSB 7
`define XCVR_CTRL_W 9
`define XCVR_CTRL_RST 9'h006

// ==================================================
// Status register fields
`define XCVR_ST_OVF_BIT 0
`define XCVR_ST_EMPTY_BIT 1
`define XCVR_ST_FULL_BIT 2
`define XCVR_ST_DRVA_LSB 4
`define XCVR_ST_DRVB_LSB 6

// ==================================================
// Capture log fields and transceiver size
`define XCVR_LOG_EMPTY_BIT 8
`define XCVR_LOG_DEPTH 4
`define XCVR_HALVES 2
`define XCVR_HALF_W 8

`endif

/* rtl/xcvr_log_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module xcvr_log_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready_o = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];

    // ==================================================
    // Storage and pointers
    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
        if (rst_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // xcvr_log_fifo

/* rtl/xcvr_half.v */
// One independent half: pin synchronisers, capture registers and bus drive
`timescale 1ns/1ps
module xcvr_half #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] a_pin_i,
    input wire [W-1:0] b_pin_i,
    input wire a_to_b_capture_clock_i,
    input wire b_to_a_capture_clock_i,
    input wire drive_en_n_i,
    input wire dir_i,
    input wire b_side_source_select_i,
    input wire a_side_source_select_i,
    output reg [W-1:0] a_o,
    output reg a_oe_o,
    output reg [W-1:0] b_o,
    output reg b_oe_o,
    output reg [W-1:0] a_reg_o,
    output reg [W-1:0] b_reg_o,
    output wire cap_a_o,
    output wire cap_b_o
);
    reg [W-1:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
    reg [2:0] cab_q, cba_q;
    reg [W-1:0] b_drv_d, a_drv_d;

    // ==================================================
    // Pin synchronisers
    always @(posedge clk_i) begin
        a_s1_q <= a_pin_i;
        a_s2_q <= a_s1_q;
        b_s1_q <= b_pin_i;
        b_s2_q <= b_s1_q;
        cab_q <= {cab_q[1:0], a_to_b_capture_clock_i};
        cba_q <= {cba_q[1:0], b_to_a_capture_clock_i};
    end

    assign cap_a_o = cab_q[1] & ~cab_q[2];
    assign cap_b_o = cba_q[1] & ~cba_q[2];

    // ==================================================
    // Capture registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_reg_o <= {W{1'b0}};
            b_reg_o <= {W{1'b0}};
        end else begin
            if (cap_a_o) begin
                a_reg_o <= a_s2_q;
            end
            if (cap_b_o) begin
                b_reg_o <= b_s2_q;
            end
        end
    end

    // ==================================================
    // Source selection and drive
    always @* begin
        b_drv_d = b_side_source_select_i ? a_reg_o : a_s2_q;
        a_drv_d = a_side_source_select_i ? b_reg_o : b_s2_q;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            a_o <= {W{1'b0}};
            b_o <= {W{1'b0}};
            a_oe_o <= 1'b0;
            b_oe_o <= 1'b0;
        end else begin
            a_o <= a_drv_d;
            b_o <= b_drv_d;
            a_oe_o <= ~drive_en_n_i & ~dir_i;
            b_oe_o <= ~drive_en_n_i & dir_i;
        end
    end
endmodule // xcvr_half

/* bench/bus_agent.sv */
// Model of the outside agents on one parallel bus
`timescale 1ns/1ps
module bus_agent (
    input logic [15:0] val_i,
    input logic [15:0] dut_o_i,
    input logic [15:0] dut_oe_i,
    output logic [15:0] line_o
);
    // ==========
    // Line resolution
    // release driven lines
    assign line_o = (dut_oe_i & dut_o_i) | (~dut_oe_i & val_i);
endmodule // bus_agent

/* bench/xcvr_chk_sva.sv */
// Port checker for the registered bus transceiver
`timescale 1ns/1ps
module xcvr_chk (
    input logic clk_i,
    input logic rst_i,
    input logic cyc_i,
    input logic stb_i,
    input logic ack_o,
    input logic [15:0] a_i,
    input logic [15:0] a_o,
    input logic [15:0] a_oe_o,
    input logic [15:0] b_i,
    input logic [15:0] b_o,
    input logic [15:0] b_oe_o,
    input logic [1:0] a_to_b_capture_clock_i,
    input logic [1:0] drive_en_n_i,
    input logic [1:0] dir_i,
    input logic [1:0] b_side_source_select_i,
    input logic [1:0] a_side_source_select_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Assertions and cover properties
    never_both_a: assert property ((a_oe_o & b_oe_o) == 16'h0000)
        else $error("both buses driven");
    oe_uniform_a: assert property (a_oe_o[7:0] inside {8'h00, 8'hff} && b_oe_o[15:8] inside {8'h00, 8'hff})
        else $error("half enable split");
    disabled_idle_a: assert property (drive_en_n_i[1] [*5] |-> a_oe_o[15:8] == 8'h00 && b_oe_o[15:8] == 8'h00)
        else $error("disabled half drives");
    drive_b_a: assert property ((!drive_en_n_i[0] && dir_i[0]) [*5] |-> b_oe_o[7:0] == 8'hff)
        else $error("b not driven");
    drive_a_a: assert property ((!drive_en_n_i[1] && !dir_i[1]) [*5] |-> a_oe_o[15:8] == 8'hff)
        else $error("a not driven");
    live_to_b_a: assert property ((!drive_en_n_i[0] && dir_i[0] && !b_side_source_select_i[0]
        && $stable(a_i[7:0])) [*5] |-> b_o[7:0] == a_i[7:0]) else $error("b not live a");
    live_to_a_a: assert property ((!drive_en_n_i[1] && !dir_i[1] && !a_side_source_select_i[1]
        && $stable(b_i[15:8])) [*5] |-> a_o[15:8] == b_i[15:8]) else $error("a not live b");
    stored_hold_a: assert property ((!drive_en_n_i[0] && dir_i[0] && b_side_source_select_i[0]
        && $stable(a_to_b_capture_clock_i[0])) [*6] |-> $stable(b_o[7:0])) else $error("stored b moved");
    ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack timing");
    cover property (!drive_en_n_i[0] && dir_i[0] && b_side_source_select_i[0]);
    cover property (!drive_en_n_i[1] && !dir_i[1] && a_side_source_select_i[1]);
    cover property (ack_o);
endmodule // xcvr_chk

/* bench/tb_top.sv */
// Self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb_top;
    typedef struct {logic [1:0] en_n, dir, bsel, asel; logic [15:0] a_oe, a, b_oe, b;} row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, log_ready_o;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [15:0] a_i, b_i, a_o, b_o, a_oe_o, b_oe_o, a_val = 16'h0, b_val = 16'h0;
    logic [1:0] cab = 2'b00, cba = 2'b00, en_n = 2'b11, dir = 2'b00, bsel = 2'b00, asel = 2'b00;
    int fails = 0, total_checks = 0;
    row_t rows [7] = '{'{2'b11, 2'b11, 2'b00, 2'b00, 16'h0, 16'h0, 16'h0, 16'h0},
        '{2'b00, 2'b11, 2'b00, 2'b00, 16'h0, 16'h0, 16'hffff, 16'h1234},
        '{2'b00, 2'b11, 2'b11, 2'b00, 16'h0, 16'h0, 16'hffff, 16'h5aa5},
        '{2'b00, 2'b00, 2'b00, 2'b00, 16'hffff, 16'h8765, 16'h0, 16'h0},
        '{2'b00, 2'b00, 2'b00, 2'b11, 16'hffff, 16'hc33c, 16'h0, 16'h0},
        '{2'b01, 2'b10, 2'b00, 2'b00, 16'h0, 16'h0, 16'hff00, 16'h1200},
        '{2'b00, 2'b01, 2'b11, 2'b11, 16'hff00, 16'hc300, 16'h00ff, 16'h00a5}};
    always #20 clk_i = ~clk_i;
    xcvr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .a_i(a_i), .a_o(a_o), .a_oe_o(a_oe_o),
        .b_i(b_i), .b_o(b_o), .b_oe_o(b_oe_o), .a_to_b_capture_clock_i(cab), .b_to_a_capture_clock_i(cba),
        .drive_en_n_i(en_n), .dir_i(dir), .b_side_source_select_i(bsel), .a_side_source_select_i(asel),
        .log_ready_o(log_ready_o));
    bus_agent agent_a (.val_i(a_val), .dut_o_i(a_o), .dut_oe_i(a_oe_o), .line_o(a_i));
    bus_agent agent_b (.val_i(b_val), .dut_o_i(b_o), .dut_oe_i(b_oe_o), .line_o(b_i));
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= ad; dat_i <= d;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (ack_o !== 1'b1) begin fails++; finish_test(); end
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cap(input logic [1:0] ab, input logic [1:0] ba);
        repeat (8) @(posedge clk_i);
        cab <= ab; cba <= ba;
        repeat (4) @(posedge clk_i);
        cab <= 2'b00; cba <= 2'b00;
        repeat (6) @(posedge clk_i);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h00000006)
        wb(1'b0, 8'h14, 32'h0); `CHK(rd, 32'h00000000)
        wb(1'b0, 8'h04, 32'h0); `CHK(rd, 32'h00000002)
        a_val <= 16'h5aa5; b_val <= 16'hc33c;
        cap(2'b11, 2'b11);
        wb(1'b0, 8'h08, 32'h0); `CHK(rd, 32'hc33c5aa5)
        a_val <= 16'h1234; b_val <= 16'h8765;
        foreach (rows[i]) begin
            en_n <= rows[i].en_n; dir <= rows[i].dir; bsel <= rows[i].bsel; asel <= rows[i].asel;
            repeat (8) @(posedge clk_i);
            `CHK(a_oe_o, rows[i].a_oe)
            `CHK(a_o & rows[i].a_oe, rows[i].a)
            `CHK(b_oe_o, rows[i].b_oe)
            `CHK(b_o & rows[i].b_oe, rows[i].b)
        end
        en_n <= 2'b00; dir <= 2'b11; bsel <= 2'b00;
        cap(2'b11, 2'b11);
        wb(1'b0, 8'h08, 32'h0); `CHK(rd, 32'h12341234)
        en_n <= 2'b11; a_val <= 16'hbeef; b_val <= 16'h0f0f;
        cap(2'b01, 2'b01);
        wb(1'b0, 8'h08, 32'h0); `CHK(rd, 32'h120f12ef)
        cap(2'b11, 2'b00);
        `CHK(log_ready_o, 1'b0)
        cap(2'b11, 2'b00);
        wb(1'b0, 8'h04, 32'h0); `CHK(rd, 32'h00000005)
        wb(1'b0, 8'h0c, 32'h0); `CHK(rd, 32'h0000000f)
        wb(1'b0, 8'h10, 32'h0); `CHK(rd, 32'hc33c5aa5)
        repeat (3) wb(1'b0, 8'h10, 32'h0);
        wb(1'b1, 8'h04, 32'h1);
        wb(1'b0, 8'h04, 32'h0); `CHK(rd, 32'h00000002)
        `CHK(log_ready_o, 1'b1)
        wb(1'b0, 8'h0c, 32'h0); `CHK(rd, 32'h00000100)
        wb(1'b1, 8'h00, 32'h2d);
        wb(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h0000002d)
        wb(1'b0, 8'h04, 32'h0); `CHK(rd, 32'h00000042)
        `CHK(b_oe_o, 16'h00ff)
        `CHK(a_oe_o, 16'h0000)
        `CHK(b_o & 16'h00ff, 16'h00ef)
        finish_test();
    end
endmodule // tb_top
bind xcvr_top xcvr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .a_i(a_i), .a_o(a_o), .a_oe_o(a_oe_o), .b_i(b_i), .b_o(b_o), .b_oe_o(b_oe_o), .drive_en_n_i(drive_en_n_i),
    .a_to_b_capture_clock_i(a_to_b_capture_clock_i), .dir_i(dir_i),
    .b_side_source_select_i(b_side_source_select_i), .a_side_source_select_i(a_side_source_select_i));
